// ### pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3
  import spi_prog_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_pin,
  output logic      o_level
);
  sync_s s;
  sync_s next_s;

  // ----------------------------------------------------------------------
  // next state: only ff2/ff3 are compared, ff1 feeds ff2 alone
  // ----------------------------------------------------------------------
  always_comb begin
    next_s     = s;
    next_s.ff1 = i_pin;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    if (s.ff2 == s.ff3) begin
      next_s.out = s.ff3;
    end
  end

  // registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.out;
endmodule // pin_sync3

// ### spi_host_model.sv
// serial host model that sends command frames to the sequencer
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_spi_q,
  output logic      o_spi_sel_n,
  output logic      o_spi_clk,
  output logic      o_serial_input_line
);
  logic [7:0] tx [0:71];  // frame bytes in send order
  logic [7:0] rx;         // last eight bits seen on the return line
  int         slow;       // extra low-phase cycles for a lazy host

  initial begin
    o_spi_sel_n = 1'b1;
    o_spi_clk = 1'b0;
    o_serial_input_line = 1'b0;
    rx = 8'h00;
    slow = 0;
  end

  // released data line wanders so a stale bit never passes for data
  always @(posedge i_clk_sys) begin
    if (o_spi_sel_n) begin
      o_serial_input_line <= ~o_serial_input_line;
    end
  end

  // ----------------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------------
  // clock idles low; whole command in one frame, select held low throughout
  task automatic xfer(input int nbits);
    @(posedge i_clk_sys) o_spi_sel_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    for (int i = 0; i < nbits; i++) begin
      @(posedge i_clk_sys);
      o_spi_clk <= 1'b0;
      o_serial_input_line <= tx[i/8][7-(i%8)];
      repeat (3 + slow) @(posedge i_clk_sys);
      @(posedge i_clk_sys) o_spi_clk <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      #1 rx = {rx[6:0], i_spi_q};  // late in the high phase, after the answer settled
    end
    @(posedge i_clk_sys) o_spi_clk <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_spi_sel_n <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
  endtask
endmodule // spi_host_model

// ### spi_prog_consts.svh
// constants for the serial program/erase/reset sequencer
`ifndef SPI_PROG_CONSTS_SVH
`define SPI_PROG_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define CLK_MHZ             100
`define PROG_TIME_US        100
`define ERASE_TIME_US       1000
`define RESET_PULSE_MIN_NS  100
`define RESET_ABORT_MAX_US  40
`define TIMER_W             20

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OPC_WRITE_ENABLE    8'h06
`define OPC_STATUS_READ     8'h05
`define OPC_PAGE_PROGRAM    8'h02
`define OPC_SECTOR_ERASE    8'hD8

// ----------------------------------------------------------------------
// address layout
// ----------------------------------------------------------------------
`define ADDR_W              24
`define PAGE_BYTES          64
`define PAGE_COL_W          6
`define SECTOR_LSB          17
`define SECTOR_W            7
`define SECTOR_COUNT        8'h80
`define ERASED_BYTE         8'hFF
`define STRAP_SETTLE        3'h5  // filter output trails the pin by four edges

`endif

// ### spi_prog_pkg.sv
// types shared by the serial program/erase/reset sequencer
package spi_prog_pkg;
  `include "spi_prog_consts.svh"

  // serial frame phase
  typedef enum logic [5:0] {
    F_IDLE = 6'b000001,
    F_CMD  = 6'b000010,
    F_ADDR = 6'b000100,
    F_DATA = 6'b001000,
    F_STAT = 6'b010000,
    F_IGN  = 6'b100000
  } frame_e;

  // self-timed operation in flight
  typedef enum logic [2:0] {
    OP_NONE  = 3'b001,
    OP_PROG  = 3'b010,
    OP_ERASE = 3'b100
  } op_e;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic out;
  } sync_s;

  typedef struct packed {
    frame_e                                frame;
    op_e                                   op;
    logic [7:0]                            opcode;
    logic [7:0]                            shift;
    logic [2:0]                            bit_cnt;
    logic [1:0]                            addr_cnt;
    logic [`ADDR_W-1:0]                    addr;
    logic [`PAGE_COL_W-1:0]                col;
    logic [`PAGE_BYTES-1:0][7:0]           page;
    logic [`PAGE_BYTES-1:0]                mask;
    logic                                  data_seen;
    logic [`TIMER_W-1:0]                   timer;
    logic [`PAGE_COL_W:0]                  walk;
    logic                                  clk_prev;
    logic                                  sel_prev;
    logic [2:0]                            strap_cnt;
    logic                                  strap_done;
    logic                                  serial;
    logic                                  in_progress_flag;
    logic                                  write_enable_latch;
    logic                                  q;
    logic                                  q_oe;
    logic [2:0]                            out_cnt;
    logic                                  mem_we;
    logic                                  mem_erase;
    logic [`ADDR_W-1:0]                    mem_addr;
    logic [7:0]                            mem_wdata;
  } seq_s;
endpackage

// ### spi_program_erase_reset_sequencer.sv
// serial page-program / sector-erase sequencer with strap select and reset
// Function
// RULE1: select rising before last data byte completes discards the page program
// RULE2: valid page program starts timed cycle; in-progress flag 1 during, 0 after
// RULE3: write-enable latch cleared sometime during any program or erase cycle
// RULE4: during program cycle only status read is accepted, others ignored
// RULE5: host should send consecutive bytes in one program command
// RULE6: sector erase sets every byte of the sector to all ones
// RULE7: sector erase needs a prior write enable
// RULE8: decoded write enable sets the write-enable latch
// RULE9: host lowers select, sends erase opcode and three address bytes
// RULE10: any byte address within a sector selects that sector
// RULE11: host keeps select low for the whole erase sequence
// RULE12: select rising not right after third address byte drops the erase
// RULE13: valid erase starts timed cycle; in-progress flag 1 during, 0 after
// RULE14: during erase cycle only status read is accepted, others ignored
// RULE15: erase aimed into guarded region is refused
// RULE16: strap sampled at power-up: low parallel x16, high serial
// RULE17: selected interface stays fixed until next power-up (code re-samples the strap after every reset)
// RULE18: while reset is low the device is disabled, inputs ignored
// RULE19: host holds reset low at least the minimum pulse width
// RULE20: reset during busy cycle aborts it within the abort limit
// RULE21: reset while idle completes within the minimum reset pulse width
// RULE22: program data wraps in 64-byte page; last 64 bytes are kept
// RULE23: any guard bit set protects its region from program and erase
// RULE24: each serial bit is latched on the serial clock rising edge
// RULE25: status read returns live in-progress and write-enable bits
`timescale 1ns/1ps
module spi_program_erase_reset_sequencer
  import spi_prog_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = `PROG_TIME_US * `CLK_MHZ,
  parameter int unsigned ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_nrst,
  input  wire logic                i_spi_sel_n,
  input  wire logic                i_spi_clk,
  input  wire logic                i_serial_input_line,
  input  wire logic                i_interface_strap,
  input  wire logic [3:0]          i_region_guard_bits,
  output logic                     o_spi_q,
  output logic                     o_spi_q_oe,
  output logic                     o_serial_mode,
  output logic                     o_in_progress_flag,
  output logic                     o_write_enable_latch,
  output logic                     o_mem_we,
  output logic                     o_mem_erase,
  output logic [`ADDR_W-1:0]       o_mem_addr,
  output logic [7:0]               o_mem_wdata
);
  seq_s                    s;
  seq_s                    next_s;
  logic                    sel_n;
  logic                    sck;
  logic                    din;
  logic                    strap;
  logic                    sck_rise;
  logic                    sck_fall;
  logic                    sel_fall;
  logic                    sel_rise;
  logic                    byte_done;
  logic [7:0]              rx_byte;
  logic [7:0]              status;
  logic [7:0]              guard_lim;
  logic                    guarded;
  logic                    exec_ok;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  pin_sync3 #(.RESET_VAL(1'b1)) u_sync_sel (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pin     (i_spi_sel_n),
    .o_level   (sel_n)
  );
  pin_sync3 #(.RESET_VAL(1'b0)) u_sync_sck (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pin     (i_spi_clk),
    .o_level   (sck)
  );
  pin_sync3 #(.RESET_VAL(1'b0)) u_sync_din (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pin     (i_serial_input_line),
    .o_level   (din)
  );
  pin_sync3 #(.RESET_VAL(1'b0)) u_sync_strap (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pin     (i_interface_strap),
    .o_level   (strap)
  );

  // ----------------------------------------------------------------------
  // edges and decode helpers
  // ----------------------------------------------------------------------
  // data and clock share the same filter delay, so din is aligned to sck_rise
  assign sck_rise  = sck & ~s.clk_prev;
  assign sck_fall  = ~sck & s.clk_prev;
  assign sel_fall  = ~sel_n & s.sel_prev;
  assign sel_rise  = sel_n & ~s.sel_prev;
  assign byte_done = sck_rise && (s.bit_cnt == 3'h7);
  assign rx_byte   = {s.shift[6:0], din};
  // top/bottom bit reads as zero, so only upper regions are guarded
  assign status    = {1'b0, i_region_guard_bits[3], 1'b0, i_region_guard_bits[2:0],
                      s.write_enable_latch, s.in_progress_flag}; // [RULE25]

  // guarded span: sectors from 128 - 2^(n-1) upward, or all when bit 3 set
  assign guard_lim = `SECTOR_COUNT - (8'h01 << (i_region_guard_bits[2:0] - 3'h1));
  assign guarded   = i_region_guard_bits[3] ||
                     ((i_region_guard_bits[2:0] != 3'h0) &&
                      ({1'b0, s.addr[`ADDR_W-1:`SECTOR_LSB]} >= guard_lim)); // [RULE23] [RULE10]

  // frame ended exactly on a byte boundary of a complete sequence
  assign exec_ok   = sel_rise && (s.frame == F_DATA) && (s.bit_cnt == 3'h0) &&
                     (s.op == OP_NONE); // [RULE1] [RULE12]

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.mem_we    = 1'b0;
    next_s.mem_erase = 1'b0;
    next_s.clk_prev  = sck;
    next_s.sel_prev  = sel_n;

    // interface choice: caught once after the strap filter settles
    if (!s.strap_done) begin
      next_s.strap_cnt = s.strap_cnt + 3'h1;
      if (s.strap_cnt == `STRAP_SETTLE) begin
        next_s.serial     = strap; // [RULE16]
        next_s.strap_done = 1'b1;  // [RULE17]
      end
    end

    // self-timed engine
    case (s.op)
      OP_PROG: begin
        next_s.write_enable_latch = 1'b0; // [RULE3]
        if (!s.walk[`PAGE_COL_W]) begin
          next_s.walk = s.walk + 7'h01;
          if (s.mask[s.walk[`PAGE_COL_W-1:0]]) begin
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = {s.addr[`ADDR_W-1:`PAGE_COL_W], s.walk[`PAGE_COL_W-1:0]};
            next_s.mem_wdata = s.page[s.walk[`PAGE_COL_W-1:0]]; // [RULE22]
          end
        end
        if (s.timer != '0) begin
          next_s.timer = s.timer - 20'h00001;
        end else begin
          next_s.op  = OP_NONE;
          next_s.in_progress_flag = 1'b0; // [RULE2]
        end
      end
      OP_ERASE: begin
        next_s.write_enable_latch = 1'b0; // [RULE3]
        if (s.walk == 7'h00) begin
          next_s.walk      = 7'h01;
          next_s.mem_erase = 1'b1;
          next_s.mem_addr  = {s.addr[`ADDR_W-1:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}}; // [RULE10]
          next_s.mem_wdata = `ERASED_BYTE; // [RULE6]
        end
        if (s.timer != '0) begin
          next_s.timer = s.timer - 20'h00001;
        end else begin
          next_s.op  = OP_NONE;
          next_s.in_progress_flag = 1'b0; // [RULE13]
        end
      end
      default: begin
        next_s.op = OP_NONE;
      end
    endcase

    // serial frame: a parallel-strapped part never answers the serial pins
    if (!s.serial) begin
      next_s.frame = F_IDLE;
      next_s.q_oe  = 1'b0;
    end else if (sel_fall) begin
      next_s.frame    = F_CMD;
      next_s.bit_cnt  = 3'h0;
      next_s.addr_cnt = 2'h0;
      next_s.out_cnt  = 3'h0;
      next_s.q_oe     = 1'b0;
    end else if (sel_n) begin
      next_s.frame = F_IDLE;
      next_s.q_oe  = 1'b0;
      if (exec_ok) begin
        case (s.opcode)
          `OPC_WRITE_ENABLE: begin
            next_s.write_enable_latch = 1'b1; // [RULE8]
          end
          `OPC_SECTOR_ERASE: begin
            if (!guarded) begin // [RULE15]
              next_s.op    = OP_ERASE;
              next_s.in_progress_flag   = 1'b1; // [RULE13]
              next_s.timer = 20'(ERASE_CYCLES);
              next_s.walk  = 7'h00;
            end
          end
          `OPC_PAGE_PROGRAM: begin
            if (s.data_seen && !guarded) begin // [RULE23]
              next_s.op    = OP_PROG;
              next_s.in_progress_flag   = 1'b1; // [RULE2]
              next_s.timer = 20'(PROG_CYCLES);
              next_s.walk  = 7'h00;
            end
          end
          default: begin
            next_s.in_progress_flag = s.in_progress_flag;
          end
        endcase
      end
    end else begin
      // bits latched on the serial clock rising edge
      if (sck_rise) begin
        next_s.shift   = rx_byte; // [RULE24]
        next_s.bit_cnt = s.bit_cnt + 3'h1;
      end
      case (s.frame)
        F_CMD: begin
          if (byte_done) begin
            next_s.opcode = rx_byte;
            if (rx_byte == `OPC_STATUS_READ) begin
              next_s.frame = F_STAT;
            end else if (s.op != OP_NONE) begin
              next_s.frame = F_IGN; // [RULE4] [RULE14]
            end else if (rx_byte == `OPC_WRITE_ENABLE) begin
              next_s.frame = F_DATA;
            end else if ((rx_byte == `OPC_PAGE_PROGRAM || rx_byte == `OPC_SECTOR_ERASE) && s.write_enable_latch) begin
              next_s.frame     = F_ADDR; // [RULE7]
              next_s.mask      = '0;
              next_s.data_seen = 1'b0;
            end else begin
              next_s.frame = F_IGN;
            end
          end
        end
        F_ADDR: begin
          if (byte_done) begin
            next_s.addr     = {s.addr[15:0], rx_byte}; // [RULE24]
            next_s.addr_cnt = s.addr_cnt + 2'h1;
            if (s.addr_cnt == 2'h2) begin
              next_s.frame = F_DATA;
              next_s.col   = rx_byte[`PAGE_COL_W-1:0];
            end
          end
        end
        F_DATA: begin
          if (s.opcode != `OPC_PAGE_PROGRAM) begin
            // any extra clock after a complete sequence spoils it
            if (sck_rise) begin
              next_s.frame = F_IGN; // [RULE12]
            end
          end else if (byte_done) begin
            // column wraps in the page, later bytes overwrite earlier ones
            next_s.page[s.col] = rx_byte; // [RULE22]
            next_s.mask[s.col] = 1'b1;
            next_s.col         = s.col + 6'h01;
            next_s.data_seen   = 1'b1;
          end
        end
        F_STAT: begin
          if (sck_fall) begin
            next_s.q       = status[~s.out_cnt]; // [RULE25]
            next_s.q_oe    = 1'b1;
            next_s.out_cnt = s.out_cnt + 3'h1;
          end
        end
        default: begin
          next_s.frame = s.frame;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers: reset is asynchronous, so a busy cycle aborts at once
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin // [RULE18] [RULE20] [RULE21]
      s          <= '0;
      s.frame    <= F_IDLE;
      s.op       <= OP_NONE;
      s.clk_prev <= 1'b0;
      s.sel_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_spi_q              = s.q;
  assign o_spi_q_oe           = s.q_oe;
  assign o_serial_mode        = s.serial;
  assign o_in_progress_flag   = s.in_progress_flag;
  assign o_write_enable_latch = s.write_enable_latch;
  assign o_mem_we             = s.mem_we;
  assign o_mem_erase          = s.mem_erase;
  assign o_mem_addr           = s.mem_addr;
  assign o_mem_wdata          = s.mem_wdata;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  prog_start_a: assert property (exec_ok && s.opcode == `OPC_PAGE_PROGRAM && s.data_seen && !guarded // [RULE2]
    |=> o_in_progress_flag ##1 !o_write_enable_latch)
    else $error("page program did not start");
  erase_start_a: assert property (exec_ok && s.opcode == `OPC_SECTOR_ERASE && !guarded // [RULE13]
    |=> o_in_progress_flag ##1 o_mem_erase)
    else $error("sector erase did not start");
  guard_block_a: assert property (exec_ok && s.opcode == `OPC_SECTOR_ERASE && guarded // [RULE15]
    |=> !o_in_progress_flag)
    else $error("erase into guarded region started");
  wel_clear_a: assert property ((s.op != OP_NONE) ##1 (s.op != OP_NONE) // [RULE3]
    |-> !o_write_enable_latch)
    else $error("write enable latch held during busy cycle");
  busy_ignore_a: assert property ((s.op != OP_NONE) && s.frame == F_CMD && byte_done && !sel_n && // [RULE4]
    rx_byte != `OPC_STATUS_READ |=> s.frame == F_IGN)
    else $error("command taken while busy");
  write_enable_cmd_set_a: assert property (exec_ok && s.opcode == `OPC_WRITE_ENABLE // [RULE8]
    |=> o_write_enable_latch)
    else $error("write enable not latched");
  no_wel_a: assert property (s.serial && !sel_n && !sel_fall && s.frame == F_CMD && byte_done && // [RULE7]
    !s.write_enable_latch && rx_byte == `OPC_SECTOR_ERASE |=> s.frame == F_IGN)
    else $error("erase accepted without write enable");
  mode_fixed_a: assert property (s.strap_done |=> $stable(o_serial_mode)) // [RULE17]
    else $error("interface mode changed");
  erase_ff_a: assert property (o_mem_erase |-> o_mem_wdata == `ERASED_BYTE && // [RULE6]
    o_mem_addr[`SECTOR_LSB-1:0] == '0)
    else $error("erase not all ones");
  partial_drop_a: assert property (sel_rise && s.frame == F_DATA && s.bit_cnt != 3'h0 && // [RULE1]
    !o_in_progress_flag |=> !o_in_progress_flag)
    else $error("partial frame executed");
endmodule // spi_program_erase_reset_sequencer

// ### tb_top.sv
// self-checking bench for the serial program/erase/reset sequencer
`timescale 1ns/1ps
`include "spi_prog_consts.svh"
module tb_top
  import spi_prog_pkg::*;
;
  localparam int unsigned PROG_N  = 600;
  localparam int unsigned ERASE_N = 1000;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 strap = 1'b1;
  logic [3:0]           guard = 4'h0;
  wire logic            sel_n, sck, mosi, q, q_oe, mode, in_progress_flag, write_enable_latch, mwe, mer;
  wire logic [`ADDR_W-1:0] maddr;
  wire logic [7:0]      mdata;
  int                   n_fail, checks_done, cyc, we_cnt, er_cnt, busy_len, b0, e0;
  logic [7:0]           wr [0:63];
  logic [17:0]          wr_pg;
  logic [23:0]          er_addr;
  logic [7:0]           er_data, st;
  logic [3:0]           g_tab [0:2] = '{4'h8, 4'h1, 4'h1};
  logic [23:0]          a_tab [0:2] = '{24'h000000, 24'hFE0000, 24'hFC0000};
  logic [7:0]           s_tab [0:2] = '{8'h42, 8'h06, 8'h06};
  int                   n_tab [0:2] = '{39, 31, 40};

  always #5 clk = ~clk;

  spi_program_erase_reset_sequencer #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) dut_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_spi_sel_n(sel_n), .i_spi_clk(sck),
    .i_serial_input_line(mosi), .i_interface_strap(strap), .i_region_guard_bits(guard),
    .o_spi_q(q), .o_spi_q_oe(q_oe), .o_serial_mode(mode), .o_in_progress_flag(in_progress_flag),
    .o_write_enable_latch(write_enable_latch), .o_mem_we(mwe), .o_mem_erase(mer), .o_mem_addr(maddr),
    .o_mem_wdata(mdata));

  spi_host_model host_u (.i_clk_sys(clk), .i_spi_q(q), .o_spi_sel_n(sel_n), .o_spi_clk(sck),
    .o_serial_input_line(mosi));

  // ----------------------------------------------------------------------
  // memory-side monitor and hang guard
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (mwe === 1'b1) begin
      we_cnt++;
      wr[maddr[5:0]] = mdata;
      wr_pg = maddr[23:6];
    end
    if (mer === 1'b1) begin
      er_cnt++;
      er_addr = maddr;
      er_data = mdata;
    end
    if (in_progress_flag === 1'b1) busy_len++;
    if (cyc == 40000) begin  // whole plan needs about 12300 cycles
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // opcode, three address bytes, nd data bytes, cut to nbits
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd, input int nbits);
    host_u.tx[0] = op;
    host_u.tx[1] = a[23:16];
    host_u.tx[2] = a[15:8];
    host_u.tx[3] = a[7:0];
    for (int k = 0; k < nd; k++) host_u.tx[4+k] = 8'h10 + k[7:0];
    host_u.xfer(nbits);
  endtask

  task automatic write_enable_cmd();
    cmd(`OPC_WRITE_ENABLE, 24'h0, 0, 8);
  endtask

  task automatic status(output logic [7:0] s);
    host_u.tx[0] = `OPC_STATUS_READ;
    host_u.xfer(16);
    s = host_u.rx;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000 && in_progress_flag !== 1'b0; i++) @(posedge clk);
    chk("idle", in_progress_flag, 1'b0);
  endtask

  // reset pulse of 20 cycles, well over the minimum width
  task automatic do_reset(input logic s);
    @(posedge clk);
    strap <= s;
    nrst <= 1'b0;
    #1 chk("rst_now", {in_progress_flag, write_enable_latch}, 2'b00);
    repeat (20) @(posedge clk);
    chk("rst_hold", {in_progress_flag, write_enable_latch, mwe, mer, q_oe, mode}, 6'h00);
    nrst <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset(1'b1);
    chk("mode", mode, 1'b1);
    status(st);
    chk("st_idle", st, 8'h00);
    cmd(`OPC_SECTOR_ERASE, 24'h040000, 0, 32);
    repeat (20) @(posedge clk);
    chk("se_no_latch", {in_progress_flag, 8'(er_cnt)}, 9'h000);
    write_enable_cmd();
    host_u.slow = 3;
    status(st);
    host_u.slow = 0;
    chk("st_latch", st, 8'h02);
    // frames cut short or overlong are dropped
    for (int i = 0; i < 3; i++) begin
      write_enable_cmd();
      cmd(i == 0 ? `OPC_PAGE_PROGRAM : `OPC_SECTOR_ERASE, 24'h000040, 1, n_tab[i]);
      repeat (20) @(posedge clk);
      chk("cut_we", we_cnt, 0);
      chk("cut_er", {in_progress_flag, 8'(er_cnt)}, 9'h000);
    end
    // 66 bytes from column 5: wraps, first two overwritten
    write_enable_cmd();
    b0 = busy_len;
    cmd(`OPC_PAGE_PROGRAM, 24'h000105, 66, 560);
    status(st);
    chk("st_prog", st, 8'h01);
    write_enable_cmd();
    wait_idle();
    chk("prog_len", busy_len - b0 >= PROG_N && busy_len - b0 <= PROG_N + 2, 1'b1);
    status(st);
    chk("st_after", st, 8'h00);
    chk("we_cnt", we_cnt, 64);
    chk("page", wr_pg, 18'h4);
    chk("col5", {wr[4], wr[5], wr[6], wr[7]}, 32'h4F505112);
    // erase from an address deep inside sector 2
    write_enable_cmd();
    cmd(`OPC_SECTOR_ERASE, 24'h05ABCD, 0, 32);
    status(st);
    chk("st_erase", st, 8'h01);
    write_enable_cmd();
    cmd(`OPC_PAGE_PROGRAM, 24'h000000, 1, 40);
    wait_idle();
    chk("er_cnt", er_cnt, 1);
    chk("er_addr", er_addr, 24'h040000);
    chk("er_data", er_data, 8'hFF);
    chk("busy_we", we_cnt, 64);
    // guarded targets refused, neighbour sector accepted
    for (int i = 0; i < 3; i++) begin
      guard <= g_tab[i];
      e0 = er_cnt;
      write_enable_cmd();
      status(st);
      chk("st_guard", st, s_tab[i]);
      cmd(`OPC_SECTOR_ERASE, a_tab[i], 0, 32);
      repeat (20) @(posedge clk);
      wait_idle();
      chk("guard_er", er_cnt - e0, i == 2);
    end
    chk("er_126", er_addr, 24'hFC0000);
    // page program into the guarded top sector is refused as well
    write_enable_cmd();
    cmd(`OPC_PAGE_PROGRAM, 24'hFE0000, 1, 40);
    repeat (20) @(posedge clk);
    chk("guard_pp", {in_progress_flag, 8'(we_cnt)}, 9'h040);
    guard <= 4'h0;
    // reset in mid-erase, then reset while idle with the latch set
    write_enable_cmd();
    cmd(`OPC_SECTOR_ERASE, 24'h000000, 0, 32);
    chk("busy", in_progress_flag, 1'b1);
    do_reset(1'b1);
    write_enable_cmd();
    do_reset(1'b1);
    strap <= 1'b0;
    repeat (10) @(posedge clk);
    chk("mode_kept", mode, 1'b1);
    // parallel strap leaves the serial port dead
    do_reset(1'b0);
    chk("mode_par", mode, 1'b0);
    write_enable_cmd();
    chk("par_latch", write_enable_latch, 1'b0);
    test_done();
  end
endmodule // tb_top
